// >>> logic/free_run_gen.sv
// Free run default pattern generator: replaces decoded video when lock is lost or forced.
// Assumes decoder video and lock status are on CLK_SYS; register port is synchronous.
`timescale 1ns/10ps
`default_nettype none
module free_run_gen #(
   parameter int XW = 11,
   parameter int YW = 10
) (
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   input wire logic REG_WR,
   input wire logic [free_run_pkg::REG_AW-1:0] REG_ADDR,
   input wire logic [free_run_pkg::REG_DW-1:0] REG_WDATA,
   output logic [free_run_pkg::REG_DW-1:0] REG_RDATA,
   input wire logic DEC_LOCKED,
   input wire logic [7:0] DEC_Y,
   input wire logic [7:0] DEC_CB,
   input wire logic [7:0] DEC_CR,
   output logic [7:0] OUT_Y,
   output logic [7:0] OUT_CB,
   output logic [7:0] OUT_CR,
   output logic FREE_RUN
);
   import free_run_pkg::*;
   logic [7:0] luma_en_ff;
   logic [7:0] chroma_ff;
   logic [7:0] pattern_ff;
   logic [XW-1:0] x_ff;
   logic [YW-1:0] y_ff;
   logic [XW-1:0] last_x;
   logic [YW-1:0] last_y;
   logic free_run_now;
   logic [2:0] pat_eff;
   logic [2:0] bar_idx;
   logic [7:0] pat_y;
   logic [7:0] pat_cb;
   logic [7:0] pat_cr;
   logic [7:0] nxt_y;
   logic [7:0] nxt_cb;
   logic [7:0] nxt_cr;
   src_t src;

   // Register port: writes land on the next edge
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         luma_en_ff <= RST_LUMA_EN;
         chroma_ff <= RST_CHROMA;
         pattern_ff <= RST_PATTERN;
      end else if (REG_WR) begin
         if (REG_ADDR == OFS_LUMA_EN) luma_en_ff <= REG_WDATA;
         if (REG_ADDR == OFS_CHROMA) chroma_ff <= REG_WDATA;
         if (REG_ADDR == OFS_PATTERN) pattern_ff <= REG_WDATA;
      end
   end

   // Registered read data; unmapped addresses read zero
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         REG_RDATA <= '0;
      end else begin
         unique case (REG_ADDR)
            OFS_LUMA_EN: REG_RDATA <= luma_en_ff;
            OFS_CHROMA: REG_RDATA <= chroma_ff;
            OFS_PATTERN: REG_RDATA <= pattern_ff;
            default: REG_RDATA <= '0;
         endcase
      end
   end

   // Raster runs continuously so the output timing never stalls across lock changes
   free_run_timing #(.XW(XW), .YW(YW)) u_timing (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .std_sel(pattern_ff[POS_STD_HI:POS_STD_LO]),
      .x_ff(x_ff),
      .y_ff(y_ff),
      .last_x(last_x),
      .last_y(last_y)
   );

   function automatic logic [2:0] pat_decode(input logic [2:0] code);
      unique case (code)
         PAT_BARS, PAT_RAMP, PAT_BOX: pat_decode = code;
         default: pat_decode = PAT_SINGLE;
      endcase
   endfunction

   always_comb begin
      // Forced enable wins; auto enable only acts when lock is lost
      free_run_now = luma_en_ff[POS_FORCED] | (luma_en_ff[POS_AUTO] & ~DEC_LOCKED);
      pat_eff = pat_decode(pattern_ff[POS_PAT_HI:0]);
      // Eight equal bars across the line
      bar_idx = 3'((32'(x_ff) * 8) / (32'(last_x) + 1));
      pat_y = Y_BLACK;
      pat_cb = C_NEUTRAL;
      pat_cr = C_NEUTRAL;
      unique case (pat_eff)
         PAT_BARS: begin
            unique case (bar_idx)
               3'h0: begin pat_y = 8'hEB; pat_cb = 8'h80; pat_cr = 8'h80; end
               3'h1: begin pat_y = 8'hD2; pat_cb = 8'h10; pat_cr = 8'h92; end
               3'h2: begin pat_y = 8'hAA; pat_cb = 8'hA6; pat_cr = 8'h10; end
               3'h3: begin pat_y = 8'h91; pat_cb = 8'h36; pat_cr = 8'h22; end
               3'h4: begin pat_y = 8'h6A; pat_cb = 8'hCA; pat_cr = 8'hDE; end
               3'h5: begin pat_y = 8'h51; pat_cb = 8'h5A; pat_cr = 8'hF0; end
               3'h6: begin pat_y = 8'h29; pat_cb = 8'hF0; pat_cr = 8'h6E; end
               3'h7: begin pat_y = 8'h10; pat_cb = 8'h80; pat_cr = 8'h80; end
            endcase
         end
         PAT_RAMP: begin
            // Chroma comes from the chroma register so software can neutralise it
            pat_y = Y_BLACK + 8'({bar_idx, 4'h0}) + 8'({bar_idx, 2'h0});
            pat_cr = {chroma_ff[7:4], NIBBLE_ZERO};
            pat_cb = {chroma_ff[3:0], NIBBLE_ZERO};
         end
         PAT_BOX: begin
            if (x_ff == '0 || y_ff == '0 || x_ff == last_x || y_ff == last_y)
               pat_y = Y_WHITE;
         end
         default: begin
            pat_y = {luma_en_ff[POS_LUMA_HI:POS_LUMA_LO], {LUMA_PAD{1'b0}}};
            pat_cr = {chroma_ff[7:4], NIBBLE_ZERO};
            pat_cb = {chroma_ff[3:0], NIBBLE_ZERO};
         end
      endcase
      src = free_run_now ? SRC_PATTERN : SRC_DECODER;
      unique case (src)
         SRC_PATTERN: begin nxt_y = pat_y; nxt_cb = pat_cb; nxt_cr = pat_cr; end
         default: begin nxt_y = DEC_Y; nxt_cb = DEC_CB; nxt_cr = DEC_CR; end
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         OUT_Y <= '0;
         OUT_CB <= '0;
         OUT_CR <= '0;
         FREE_RUN <= 1'b0;
      end else begin
         OUT_Y <= nxt_y;
         OUT_CB <= nxt_cb;
         OUT_CR <= nxt_cr;
         FREE_RUN <= free_run_now;
      end
   end

   a_forced_mode: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      luma_en_ff[POS_FORCED] |=> FREE_RUN) else $error("forced enable did not give free run");
   a_auto_entry: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (luma_en_ff[POS_AUTO] && !DEC_LOCKED) |=> FREE_RUN) else $error("auto entry missed");
   a_pass_through: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (!luma_en_ff[POS_FORCED] && !luma_en_ff[POS_AUTO]) |=> (!FREE_RUN && OUT_Y == $past(DEC_Y)))
      else $error("decoder data not passed");
   a_single_luma: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (free_run_now && pattern_ff[POS_PAT_HI:0] == PAT_SINGLE) |=>
      OUT_Y == {$past(luma_en_ff[POS_LUMA_HI:POS_LUMA_LO]), 2'b00}) else $error("luma padding wrong");
   a_single_chroma: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (free_run_now && pattern_ff[POS_PAT_HI:0] == PAT_SINGLE) |=>
      (OUT_CR[7:4] == $past(chroma_ff[7:4]) && OUT_CB[7:4] == $past(chroma_ff[3:0])))
      else $error("chroma nibbles wrong");
   a_reserved_code: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (free_run_now && pattern_ff[POS_PAT_HI:0] == 3'h7) |=>
      (OUT_Y == {$past(luma_en_ff[POS_LUMA_HI:POS_LUMA_LO]), 2'b00} &&
      OUT_CR == {$past(chroma_ff[7:4]), NIBBLE_ZERO} && OUT_CB == {$past(chroma_ff[3:0]), NIBBLE_ZERO}))
      else $error("reserved code not single colour");
   a_box_corner: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (free_run_now && pat_eff == PAT_BOX && x_ff == '0) |=> OUT_Y == Y_WHITE)
      else $error("box border missing");
   a_box_inside: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (free_run_now && pat_eff == PAT_BOX && x_ff == XW'(5) && y_ff != '0 && y_ff != last_y) |=> OUT_Y == Y_BLACK)
      else $error("box interior not black");
   a_ramp_rises: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (pat_eff == PAT_RAMP && $past(pat_eff) == PAT_RAMP && bar_idx != 3'h0 && bar_idx != $past(bar_idx) && x_ff != '0)
      |-> pat_y > $past(pat_y)) else $error("ramp not brighter");
   a_reset_values: assert property (@(posedge CLK_SYS)
      $rose(ARST_N) |-> (luma_en_ff == RST_LUMA_EN && chroma_ff == RST_CHROMA))
      else $error("register reset values wrong");
endmodule
`default_nettype wire

// >>> logic/free_run_pkg.sv
// Package for the free run default pattern generator.
// Assumes an 8-bit register port with byte addresses and 8-bit pixel components.
package free_run_pkg;
   localparam int REG_AW = 8;
   localparam int REG_DW = 8;
   localparam logic [7:0] OFS_LUMA_EN = 8'h0C;
   localparam logic [7:0] OFS_CHROMA = 8'h0D;
   localparam logic [7:0] OFS_PATTERN = 8'h14;
   localparam logic [7:0] RST_LUMA_EN = 8'h36;
   localparam logic [7:0] RST_CHROMA = 8'h7C;
   localparam logic [7:0] RST_PATTERN = 8'h10;
   // Field positions
   localparam int POS_FORCED = 0;
   localparam int POS_AUTO = 1;
   localparam int POS_LUMA_LO = 2;
   localparam int POS_LUMA_HI = 7;
   localparam int POS_PAT_HI = 2;
   localparam int POS_STD_LO = 4;
   localparam int POS_STD_HI = 7;
   localparam int LUMA_PAD = 2;
   localparam int STD_W = 4;
   // Raster extents: last active pixel of a line and last active line of each family
   localparam int LAST_PIXEL = 719;
   localparam int LAST_LINE_525 = 479;
   localparam int LAST_LINE_625 = 575;
   localparam logic [2:0] PAT_SINGLE = 3'h0;
   localparam logic [2:0] PAT_BARS = 3'h1;
   localparam logic [2:0] PAT_RAMP = 3'h2;
   localparam logic [2:0] PAT_BOX = 3'h5;
   localparam logic [7:0] Y_BLACK = 8'h10;
   localparam logic [7:0] Y_WHITE = 8'hEB;
   localparam logic [7:0] C_NEUTRAL = 8'h80;
   localparam logic [3:0] NIBBLE_ZERO = 4'h0;
   typedef enum logic [1:0] {SRC_DECODER, SRC_SINGLE, SRC_PATTERN} src_t;
endpackage

// >>> logic/free_run_timing.sv
// Raster counter for free run output.
// Assumes one pixel per CLK_SYS cycle; standard select picks the frame line count, line length is fixed.
`timescale 1ns/10ps
`default_nettype none
module free_run_timing #(
   parameter int XW = 11,
   parameter int YW = 10
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [3:0] std_sel,
   output logic [XW-1:0] x_ff,
   output logic [YW-1:0] y_ff,
   output logic [XW-1:0] last_x,
   output logic [YW-1:0] last_y
);
   import free_run_pkg::*;
   localparam logic [XW-1:0] W525 = XW'(LAST_PIXEL);
   localparam logic [YW-1:0] H525 = YW'(LAST_LINE_525);
   localparam logic [YW-1:0] H625 = YW'(LAST_LINE_625);
   // Odd standard codes are the 525-line family; the rest use 625 lines
   always_comb begin
      last_x = W525;
      last_y = std_sel[0] ? H525 : H625;
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         x_ff <= '0;
         y_ff <= '0;
      end else if (x_ff >= last_x) begin
         x_ff <= '0;
         y_ff <= (y_ff >= last_y) ? '0 : y_ff + YW'(1);
      end else begin
         x_ff <= x_ff + XW'(1);
      end
   end
endmodule
`default_nettype wire

// >>> tb/free_run_default_pattern_gen_tb_top.sv
// Testbench for the free run generator: lock handling, registers, patterns.
// Assumes the package and design compile first; the sink watches the stream.
`timescale 1ns/10ps
`default_nettype none
module free_run_default_pattern_gen_tb_top;
   import free_run_pkg::*;
   logic clk_sys = 0, arst_n = 0, reg_wr = 0, locked = 1, clr = 0, fr;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, oy, ocb, ocr;
   logic [7:0] dec_y = 8'h5A, dec_cb = 8'h3C, dec_cr = 8'hA5;
   int fails = 0, checks = 0, cyc = 0, ups, downs, whites;
   typedef struct {logic [7:0] le, ch; logic lk, fr; logic [7:0] y, cb, cr;} row_t;
   row_t rows[5] = '{'{8'h36, 8'h7C, 1'b0, 1'b1, 8'h34, 8'hC0, 8'h70},
      '{8'h36, 8'h7C, 1'b1, 1'b0, 8'h5A, 8'h3C, 8'hA5}, '{8'h34, 8'h7C, 1'b0, 1'b0, 8'h5A, 8'h3C, 8'hA5},
      '{8'h35, 8'h12, 1'b1, 1'b1, 8'h34, 8'h20, 8'h10}, '{8'hFE, 8'hF0, 1'b0, 1'b1, 8'hFC, 8'h00, 8'hF0}};
   logic [2:0] pats[5] = '{3'h0, 3'h3, 3'h4, 3'h6, 3'h7};
   free_run_gen u_dut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .REG_WR(reg_wr), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_RDATA(rdata), .DEC_LOCKED(locked), .DEC_Y(dec_y), .DEC_CB(dec_cb), .DEC_CR(dec_cr), .OUT_Y(oy),
      .OUT_CB(ocb), .OUT_CR(ocr), .FREE_RUN(fr));
   pixel_sink u_sink (.clk(clk_sys), .clr(clr), .y(oy), .ups(ups), .downs(downs), .whites(whites));
   always #10 clk_sys = ~clk_sys;
   // Scans last about 730 cycles each, so 20000 leaves a wide margin
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         results();
      end
   end
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_n(input int got, input int exp);
      checks++;
      if (got != exp) begin
         fails++;
         $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      addr = a;
      wdata = d;
      reg_wr = 1;
      @(negedge clk_sys);
      reg_wr = 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_sys);
      addr = a;
      @(negedge clk_sys);
      cmp(rdata, exp);
   endtask
   // One full line of a pattern; the extra cycle lets the old pattern drain first
   task automatic scan(input logic [2:0] p, input int eu, input int ed, input int ew);
      wr(OFS_PATTERN, {4'h1, 1'b0, p});
      @(negedge clk_sys);
      clr = 1;
      @(negedge clk_sys);
      clr = 0;
      repeat (720) @(negedge clk_sys);
      cmp_n(ups, eu);
      cmp_n(downs, ed);
      cmp_n(whites, ew);
   endtask
   task automatic results();
      if (fails == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(negedge clk_sys);
      arst_n = 1;
      foreach (rows[i]) begin
         wr(OFS_CHROMA, rows[i].ch);
         locked = rows[i].lk;
         wr(OFS_LUMA_EN, rows[i].le);
         @(negedge clk_sys);
         cmp({7'h0, fr}, {7'h0, rows[i].fr});
         cmp(oy, rows[i].y);
         cmp(ocb, rows[i].cb);
         cmp(ocr, rows[i].cr);
      end
      locked = 0;
      arst_n = 0;
      @(negedge clk_sys);
      cmp({7'h0, fr}, 8'h00);
      cmp(oy, 8'h00);
      arst_n = 1;
      rd(OFS_LUMA_EN, RST_LUMA_EN);
      rd(OFS_CHROMA, RST_CHROMA);
      rd(OFS_PATTERN, RST_PATTERN);
      cmp({7'h0, fr}, 8'h01);
      cmp(oy, 8'h34);
      cmp(ocb, 8'hC0);
      cmp(ocr, 8'h70);
      wr(8'h20, 8'hFF);
      rd(8'h20, 8'h00);
      rd(OFS_LUMA_EN, 8'h36);
      wr(OFS_CHROMA, 8'h88);
      scan(PAT_RAMP, 7, 1, 0);
      cmp(ocb, C_NEUTRAL);
      cmp(ocr, C_NEUTRAL);
      scan(PAT_BARS, 1, 7, 90);
      scan(PAT_BOX, 1, 1, 2);
      foreach (pats[i]) begin
         scan(pats[i], 0, 0, 0);
         cmp(oy, 8'h34);
      end
      // Pass-through must follow a changing decoder pixel, not a fixed value
      wr(OFS_LUMA_EN, 8'h34);
      dec_y = 8'hC3;
      @(negedge clk_sys);
      cmp({7'h0, fr}, 8'h00);
      cmp(oy, 8'hC3);
      results();
   end
endmodule
`default_nettype wire

// >>> tb/pixel_sink.sv
// Downstream sink model: tallies luma steps and white pixels on the stream.
// Assumes the stream is sampled on the rising clock, one pixel per cycle.
`timescale 1ns/10ps
`default_nettype none
module pixel_sink (
   input wire logic clk,
   input wire logic clr,
   input wire logic [7:0] y,
   output int ups,
   output int downs,
   output int whites
);
   logic [7:0] prev_ff;
   // Clear also loads the reference pixel, so a scan sees every step of a line
   always_ff @(posedge clk) begin
      prev_ff <= y;
      if (clr) begin
         ups <= 0;
         downs <= 0;
         whites <= 0;
      end else begin
         ups <= ups + int'(y > prev_ff);
         downs <= downs + int'(y < prev_ff);
         whites <= whites + int'(y == 8'hEB);
      end
   end
endmodule
`default_nettype wire
